// >>> rtl/tfc_defines.svh
`ifndef TFC_DEFINES_SVH
`define TFC_DEFINES_SVH
`define TFC_COLUMNS 8'h84
`define TFC_LAST_COLUMN 8'h83
`define TFC_VCOUNT_TOP 8'h80
`define TFC_LAST_LINE 8'h7F
`define TFC_CODE_CR 7'h0D
`define TFC_CODE_LF 7'h0A
`define TFC_CODE_FF 7'h0C
`define TFC_CODE_VT 7'h0B
`define TFC_CODE_HT 7'h09
`define TFC_CODE_BS 7'h08
`define TFC_CODE_ESC 7'h1B
`define TFC_CODE_SP 7'h20
`define TFC_CODE_HSET 7'h31
`define TFC_CODE_HCLR 7'h32
`define TFC_CODE_VSET 7'h33
`define TFC_CODE_VCLR 7'h34
`define TFC_LINES_PER_INCH 8'h06
`endif

// >>> rtl/tfc_pkg.sv
package tfc_pkg;
   typedef enum logic [2:0] {
      TFC_IDLE,
      TFC_HTAB,
      TFC_VTAB,
      TFC_FORM,
      TFC_HCLEAR,
      TFC_VCLEAR,
      TFC_SEND,
      TFC_WAIT
   } tfc_state_type;
endpackage

// >>> rtl/tfc_tab_forms_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "tfc_defines.svh"
// Notes on behaviour
// - Hold the preset form length and compare against line feeds performed.
// - Form feed emits exactly the line feeds needed to reach top of form.
// - Track head column over 132 columns and store horizontal tab stops.
// - Horizontal tab emits spaces up to the next stored stop.
// - Count line advances, store vertical stops; vertical tab emits line feeds to next stop or top of form, whichever comes first.
// - Vertical stop allowed on any line; form length bounds the usable range.
// - Counting and housekeeping finish before each generated code is handed on.
// - Read the twelve position form length selector, in inches.
// - Top of form button, when idle, loads the preset for the selected form length into vertical counter.
// - Route decoded codes to horizontal, vertical and forms sections.
// - Send generated line feed and space codes back to the character buffer.
// - Spaces only from horizontal tabs; line feeds only from vertical or forms logic.
// - Sequencing started by data available, section commands and option clock.
// - Disable the receiver while any function is in progress.
// - Escape then 061 stores a horizontal tab; escape then 062 clears all.
// - No stop to the right: spaces to column 132, then suppress printing.
// - Preload 128 minus form lines; reload preset on counter overflow.
// - Column counter zero at margin, up on rightward move, down on backspace.
module tfc_tab_forms_control
   import tfc_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic opt_clk_en, // Option clock pulse
   input wire logic [6:0] rx_data, // Character from receiver
   input wire logic rx_data_avail, // Receiver data available
   input wire logic code_taken, // Terminal took generated code
   input wire logic [3:0] form_length_select, // Selector position 0..11
   input wire logic top_of_form_load_button, // Pushbutton
   output logic [6:0] gen_data, // Generated code
   output logic gen_data_oe_n, // Low while driving data line
   output logic gen_data_avail, // Generated code strobe
   output logic rx_disable, // Receiver output disable
   output logic print_suppress // Printing inhibited at last column
);
   // Pin level inputs pass two flops
   logic [6:0] rx_data_s1, rx_data_s2;
   logic [3:0] ctl_s1, ctl_s2;
   logic [3:0] sel_s1, sel_s2;
   always_ff @(posedge sys_clk) begin
      rx_data_s1 <= rx_data;
      rx_data_s2 <= rx_data_s1;
      ctl_s1 <= {opt_clk_en, rx_data_avail, code_taken, top_of_form_load_button};
      ctl_s2 <= ctl_s1;
      sel_s1 <= form_length_select;
      sel_s2 <= sel_s1;
   end
   wire opt_tick = ctl_s2[3];
   wire avail_s = ctl_s2[2];
   wire taken_s = ctl_s2[1];
   wire button_s = ctl_s2[0];
   logic avail_d, taken_d;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         avail_d <= 1'b0;
         taken_d <= 1'b0;
      end else begin
         avail_d <= avail_s;
         taken_d <= taken_s;
      end
   end
   wire char_strobe = avail_s & ~avail_d;
   wire taken_pulse = taken_s & ~taken_d;

   // Selector position to form length in inches, then lines
   function automatic logic [7:0] form_lines(input logic [3:0] pos);
      logic [7:0] inches;
      inches = (pos > 4'hB) ? 8'h0B : {4'h0, pos} + 8'h03;
      return 8'((16'(inches) * 16'(`TFC_LINES_PER_INCH)));
   endfunction
   wire [7:0] preset = `TFC_VCOUNT_TOP - form_lines(sel_s2);

   tfc_state_type state, resume;
   logic esc_seen;
   logic [7:0] hcount, vcount, saved;
   logic [6:0] code;
   logic tab_hit;
   logic [131:0] htab;
   logic [127:0] vtab;
   logic rx_dis, oe_n, strobe, suppress;

   wire cmd_cr = (rx_data_s2 == `TFC_CODE_CR);
   wire cmd_lf = (rx_data_s2 == `TFC_CODE_LF);
   wire cmd_ff = (rx_data_s2 == `TFC_CODE_FF);
   wire cmd_vt = (rx_data_s2 == `TFC_CODE_VT);
   wire cmd_ht = (rx_data_s2 == `TFC_CODE_HT);
   wire cmd_bs = (rx_data_s2 == `TFC_CODE_BS);
   wire cmd_esc = (rx_data_s2 == `TFC_CODE_ESC);
   wire htab_store_command = esc_seen & (rx_data_s2 == `TFC_CODE_HSET);
   wire htab_clear_command = esc_seen & (rx_data_s2 == `TFC_CODE_HCLR);
   wire vtab_store_command = esc_seen & (rx_data_s2 == `TFC_CODE_VSET);
   wire vtab_clear_command = esc_seen & (rx_data_s2 == `TFC_CODE_VCLR);
   wire printable = (rx_data_s2 >= `TFC_CODE_SP) & (rx_data_s2 != 7'h7F) & ~esc_seen;
   wire at_right = (hcount == `TFC_LAST_COLUMN);
   wire [7:0] vnext = 8'(vcount + 8'h01);
   // Counter spans 128 lines; the wrap reloads the form preset
   wire v_overflow = (vcount == `TFC_LAST_LINE);
   wire [7:0] vcount_adv = v_overflow ? preset : vnext;
   wire [7:0] hnext = 8'(hcount + 8'h01);
   wire next_htab_hit = (hnext <= `TFC_LAST_COLUMN) && htab[hnext];
   wire next_vtab_hit = vtab[vcount_adv[6:0]];
   wire busy = (state != TFC_IDLE);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= TFC_IDLE;
         resume <= TFC_IDLE;
         esc_seen <= 1'b0;
         hcount <= 8'h00;
         vcount <= 8'h00;
         saved <= 8'h00;
         code <= 7'h00;
         tab_hit <= 1'b0;
         htab <= '0;
         vtab <= '0;
         rx_dis <= 1'b0;
         oe_n <= 1'b1;
         strobe <= 1'b0;
         suppress <= 1'b0;
      end else begin
         rx_dis <= busy;
         if (button_s && !busy) begin
            vcount <= preset;
         end
         unique case (state)
            TFC_IDLE: begin
               if (char_strobe && !button_s) begin
                  esc_seen <= cmd_esc;
                  if (cmd_cr) begin
                     hcount <= 8'h00;
                     suppress <= 1'b0;
                  end else if (cmd_bs && hcount != 8'h00) begin
                     hcount <= 8'(hcount - 8'h01);
                     suppress <= 1'b0;
                  end else if (printable && !at_right) begin
                     hcount <= hnext;
                  end else if (printable) begin
                     suppress <= 1'b1;
                  end
                  if (cmd_lf) begin
                     vcount <= vcount_adv;
                     suppress <= 1'b0;
                  end
                  if (htab_store_command) begin
                     htab[hcount] <= 1'b1;
                  end
                  if (vtab_store_command) begin
                     vtab[vcount[6:0]] <= 1'b1;
                  end
                  if (cmd_ht) begin
                     state <= TFC_HTAB;
                  end else if (cmd_vt) begin
                     state <= TFC_VTAB;
                  end else if (cmd_ff) begin
                     state <= TFC_FORM;
                  end else if (htab_clear_command) begin
                     saved <= hcount;
                     hcount <= 8'h00;
                     state <= TFC_HCLEAR;
                  end else if (vtab_clear_command) begin
                     saved <= vcount;
                     vcount <= 8'h00;
                     state <= TFC_VCLEAR;
                  end
               end
            end
            TFC_HTAB: begin
               if (at_right || tab_hit) begin
                  tab_hit <= 1'b0;
                  state <= TFC_IDLE;
               end else if (opt_tick) begin
                  tab_hit <= next_htab_hit;
                  hcount <= hnext;
                  code <= `TFC_CODE_SP;
                  resume <= TFC_HTAB;
                  state <= TFC_SEND;
               end
            end
            TFC_VTAB, TFC_FORM: begin
               if (tab_hit) begin
                  tab_hit <= 1'b0;
                  state <= TFC_IDLE;
               end else if (opt_tick) begin
                  tab_hit <= v_overflow | ((state == TFC_VTAB) & next_vtab_hit);
                  vcount <= vcount_adv;
                  code <= `TFC_CODE_LF;
                  resume <= state;
                  state <= TFC_SEND;
               end
            end
            TFC_HCLEAR: begin
               if (opt_tick) begin
                  htab[hcount] <= 1'b0;
                  if (at_right) begin
                     hcount <= saved;
                     state <= TFC_IDLE;
                  end else begin
                     hcount <= hnext;
                  end
               end
            end
            TFC_VCLEAR: begin
               if (opt_tick) begin
                  vtab[vcount[6:0]] <= 1'b0;
                  if (vcount == `TFC_LAST_LINE) begin
                     vcount <= saved;
                     state <= TFC_IDLE;
                  end else begin
                     vcount <= vnext;
                  end
               end
            end
            TFC_SEND: begin
               oe_n <= 1'b0;
               strobe <= 1'b1;
               state <= TFC_WAIT;
            end
            TFC_WAIT: begin
               if (taken_pulse) begin
                  oe_n <= 1'b1;
                  strobe <= 1'b0;
                  state <= resume;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gen_data <= 7'h00;
      end else begin
         gen_data <= code;
      end
   end
   assign gen_data_oe_n = oe_n;
   assign gen_data_avail = strobe;
   assign rx_disable = rx_dis;
   assign print_suppress = suppress;

   // Offer and release steps of the generated code handshake
   sequence seq_send_entered;
      state == TFC_SEND ##1 state == TFC_WAIT;
   endsequence
   sequence seq_taken_seen;
      state == TFC_WAIT && taken_pulse;
   endsequence

   chk_send_strobe_held:
      assert property (@(posedge sys_clk) disable iff (rst)
         (state == TFC_WAIT && !taken_pulse) |=> strobe && !oe_n)
      else $error("strobe dropped early");
   chk_offer_after_send:
      assert property (@(posedge sys_clk) disable iff (rst)
         seq_send_entered |-> gen_data_avail && !gen_data_oe_n && gen_data == code)
      else $error("code not offered");
   chk_release_after_taken:
      assert property (@(posedge sys_clk) disable iff (rst)
         seq_taken_seen |=> !gen_data_avail && gen_data_oe_n)
      else $error("code not released");
   chk_rx_disabled_busy:
      assert property (@(posedge sys_clk) disable iff (rst)
         busy |=> rx_disable)
      else $error("receiver not disabled");
   chk_space_only_htab:
      assert property (@(posedge sys_clk) disable iff (rst)
         (state == TFC_SEND && resume == TFC_HTAB) |-> code == `TFC_CODE_SP)
      else $error("bad space code");
   chk_lf_only_vertical:
      assert property (@(posedge sys_clk) disable iff (rst)
         (state == TFC_SEND && resume != TFC_HTAB) |-> code == `TFC_CODE_LF)
      else $error("bad lf code");
   chk_column_bound:
      assert property (@(posedge sys_clk) disable iff (rst)
         hcount <= `TFC_LAST_COLUMN || state == TFC_HCLEAR)
      else $error("column overrun");
   chk_cr_home_col:
      assert property (@(posedge sys_clk) disable iff (rst)
         (state == TFC_IDLE && char_strobe && cmd_cr && !button_s) |=> hcount == 8'h00)
      else $error("cr");
   chk_bs_steps_back:
      assert property (@(posedge sys_clk) disable iff (rst)
         (state == TFC_IDLE && char_strobe && cmd_bs && !button_s && hcount != 8'h00) |=> hcount == 8'($past(hcount) - 8'h01))
      else $error("backspace column");
   chk_suppress_at_right:
      assert property (@(posedge sys_clk) disable iff (rst)
         (state == TFC_IDLE && char_strobe && printable && at_right && !button_s) |=> print_suppress)
      else $error("printing not suppressed");
   chk_overflow_reload:
      assert property (@(posedge sys_clk) disable iff (rst)
         (state == TFC_FORM && opt_tick && !tab_hit && v_overflow) |=> vcount == $past(preset))
      else $error("reload");
   chk_form_stops_top:
      assert property (@(posedge sys_clk) disable iff (rst)
         (state == TFC_FORM && tab_hit) |=> state == TFC_IDLE)
      else $error("form feed overrun");
   chk_button_loads:
      assert property (@(posedge sys_clk) disable iff (rst)
         (button_s && !busy && !(state == TFC_IDLE && char_strobe)) |=> vcount == $past(preset))
      else $error("form position load");
   chk_count_before_send:
      assert property (@(posedge sys_clk) disable iff (rst)
         (state == TFC_HTAB && opt_tick && !at_right && !tab_hit) |=> hcount == $past(hnext))
      else $error("order");
endmodule // tfc_tab_forms_control
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tfc_defines.svh"
module tb;
   logic sys_clk = 1'b0, rst = 1'b1, rx_data_avail = 1'b0, button = 1'b0, slow = 1'b0;
   logic [6:0] rx_data = 7'h00, gen_data;
   logic [3:0] sel = 4'h0;
   logic opt_clk_en, code_taken, gen_data_oe_n, gen_data_avail, rx_disable, print_suppress, was_busy;
   int spaces, feeds, others, fails = 0, comparisons = 0, cycles = 0;
   tfc_tab_forms_control i_tfc_tab_forms_control (.sys_clk(sys_clk), .rst(rst), .opt_clk_en(opt_clk_en),
      .rx_data(rx_data), .rx_data_avail(rx_data_avail), .code_taken(code_taken), .form_length_select(sel),
      .top_of_form_load_button(button), .gen_data(gen_data), .gen_data_oe_n(gen_data_oe_n),
      .gen_data_avail(gen_data_avail), .rx_disable(rx_disable), .print_suppress(print_suppress));
   tfc_terminal_model i_tfc_terminal_model (.sys_clk(sys_clk), .rst(rst), .slow(slow), .gen_data(gen_data),
      .gen_data_oe_n(gen_data_oe_n), .gen_data_avail(gen_data_avail), .code_taken(code_taken),
      .opt_clk_en(opt_clk_en), .spaces(spaces), .feeds(feeds), .others(others));
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic give_verdict();
      if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 90000) begin
         fails++;
         give_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic send_char(input logic [6:0] c);
      int n;
      @(posedge sys_clk);
      rx_data <= c;
      rx_data_avail <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rx_data_avail <= 1'b0;
      // Released line shows a changed value, not the old character
      rx_data <= ~c;
      n = 0;
      while (rx_disable !== 1'b1 && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      was_busy = (rx_disable === 1'b1);
      n = 0;
      while (rx_disable !== 1'b0 && n < 20000) begin
         @(posedge sys_clk);
         n++;
      end
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic do_cmd(input logic [6:0] c, input int exp_sp, input int exp_lf);
      int s0;
      int f0;
      s0 = spaces;
      f0 = feeds;
      send_char(c);
      check(spaces - s0, exp_sp);
      check(feeds - f0, exp_lf);
      check(others, 0);
      check(gen_data_oe_n, 1'b1);
      if (exp_sp + exp_lf > 0) check(was_busy, 1'b1);
   endtask
   task automatic esc(input logic [6:0] c);
      send_char(`TFC_CODE_ESC);
      send_char(c);
   endtask
   task automatic press_top_of_form(input logic [3:0] pos);
      @(posedge sys_clk);
      sel <= pos;
      button <= 1'b1;
      repeat (6) @(posedge sys_clk);
      button <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic test_reset();
      check({gen_data, gen_data_oe_n, gen_data_avail, rx_disable, print_suppress}, 11'h008);
   endtask
   task automatic test_htab();
      do_cmd(`TFC_CODE_HT, 131, 0);
      send_char(7'h41);
      check(print_suppress, 1'b1);
      do_cmd(`TFC_CODE_CR, 0, 0);
      check(print_suppress, 1'b0);
      repeat (5) send_char(`TFC_CODE_SP);
      esc(`TFC_CODE_HSET);
      do_cmd(`TFC_CODE_CR, 0, 0);
      repeat (3) send_char(`TFC_CODE_SP);
      send_char(`TFC_CODE_BS);
      slow <= 1'b1;
      do_cmd(`TFC_CODE_HT, 3, 0);
      slow <= 1'b0;
      do_cmd(`TFC_CODE_HT, 126, 0);
      do_cmd(`TFC_CODE_CR, 0, 0);
      esc(`TFC_CODE_HCLR);
      do_cmd(`TFC_CODE_HT, 131, 0);
      do_cmd(`TFC_CODE_CR, 0, 0);
   endtask
   task automatic test_forms();
      for (int p = 0; p < 12; p++) begin
         press_top_of_form(p[3:0]);
         send_char(`TFC_CODE_LF);
         do_cmd(`TFC_CODE_FF, 0, (p + 3) * 6 - 1);
      end
      press_top_of_form(4'h0);
      repeat (5) send_char(`TFC_CODE_LF);
      do_cmd(`TFC_CODE_FF, 0, 13);
      repeat (3) send_char(`TFC_CODE_LF);
      esc(`TFC_CODE_VSET);
      do_cmd(`TFC_CODE_FF, 0, 15);
      do_cmd(`TFC_CODE_VT, 0, 3);
      do_cmd(`TFC_CODE_VT, 0, 15);
      esc(`TFC_CODE_VCLR);
      send_char(`TFC_CODE_LF);
      do_cmd(`TFC_CODE_VT, 0, 17);
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      test_reset();
      test_htab();
      test_forms();
      give_verdict();
   end
endmodule // tb
`default_nettype wire

// >>> test/tfc_terminal_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "tfc_defines.svh"
module tfc_terminal_model (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic slow, // Stretch each acceptance
   input wire logic [6:0] gen_data, // Code from option
   input wire logic gen_data_oe_n, // Option drives line when low
   input wire logic gen_data_avail, // Option code strobe
   output logic code_taken, // Code accepted
   output logic opt_clk_en, // Option clock pulse
   output int spaces, // Spaces accepted
   output int feeds, // Line feeds accepted
   output int others // Any other code accepted
);
   int tick;
   int hold;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tick <= 0;
         hold <= 0;
         opt_clk_en <= 1'b0;
         code_taken <= 1'b0;
         spaces <= 0;
         feeds <= 0;
         others <= 0;
      end else begin
         tick <= (tick == 7) ? 0 : tick + 1;
         opt_clk_en <= (tick == 7);
         if (code_taken) begin
            // Held until the strobe drops so no edge is lost in sync
            if (!gen_data_avail) code_taken <= 1'b0;
         end else if (gen_data_avail && !gen_data_oe_n) begin
            if (hold >= (slow ? 12 : 1)) begin
               code_taken <= 1'b1;
               hold <= 0;
               if (gen_data === `TFC_CODE_SP) spaces <= spaces + 1;
               else if (gen_data === `TFC_CODE_LF) feeds <= feeds + 1;
               else others <= others + 1;
            end else begin
               hold <= hold + 1;
            end
         end
      end
   end
endmodule // tfc_terminal_model
`default_nettype wire
